// [src/mcs_misc_control.v]
// miscellaneous control register, data-ready pulse, test triggers and
// double-buffered auxiliary converter code, reached over the serial port
// assumes a mode 3 serial master; sclk, cs and din are asynchronous pins
//
// Notes on behaviour
// - External sample clock only when line 3 is input and sample period zero.
// - After reset data-ready drives line 1, active high, control at default.
// - Every data-ready pulse lasts between 100 and 200 microseconds.
// - Control bit 2 enables data-ready pulses; cleared means the line is released once any pulse ends.
// - Control bit 1 picks polarity: one active high, zero active low.
// - Control bit 0 picks line: one is line 2, zero is line 1.
// - Bit 11 starts flash checksum, self-clears, result goes to flag 6.
// - Bit 10 runs automatic self-test, posts per-sensor flags and self-clears on the same clock.
// - Bits 9 and 8 apply negative and positive stimulus while set.
// - Bit 7 enables gyroscope linear acceleration bias compensation.
// - Bit 6 enables accelerometer origin alignment.
// - Converter holding register keeps 12-bit offset-binary code, upper bits unused.
// - Holding register copies to converter input only on latch command.
// - Converter holding register resets to zero.
// - Command trigger bit starts operation and returns to zero when done.
`timescale 1ns/100ps
`default_nettype none
`include "mcs_consts.vh"

module mcs_misc_control (
  // clock and reset
  input wire clock,
  input wire srst,
  // serial port pins
  input wire spiCsN,
  input wire spiSclk,
  input wire spiDin,
  output reg spiDout_ff,
  output wire spiDoutOe,
  // sampling context
  input wire sampleTick,
  input wire gpioLine3Output,
  input wire [7:0] samplePeriod,
  output wire extClockEnable,
  // data-ready lines
  output wire ioLine1Out,
  output wire ioLine1Oe,
  output wire ioLine2Out,
  output wire ioLine2Oe,
  // automatic self-test
  output wire selfTestRun,
  input wire selfTestDone,
  input wire [5:0] selfTestFail,
  output reg [5:0] diagSensorFail_ff,
  output reg diagSensorStrobe_ff,
  // flash checksum test
  output wire memTestRun,
  input wire memTestDone,
  input wire memTestFail,
  output reg diagChecksumFail_ff,
  output reg diagChecksumStrobe_ff,
  // sensor controls
  output wire stimNegative,
  output wire stimPositive,
  output wire accelBiasCompEnable,
  output wire originAlignEnable,
  // converter input register
  output reg [11:0] converterInput_ff
);

  localparam integer DRDY_CYCLES_FULL = `MCS_DRDY_MIN_US * `MCS_CLK_MHZ;
  localparam [11:0] DRDY_CYCLES = DRDY_CYCLES_FULL[11:0];

  // pin synchronisers: index 0 sclk, 1 cs, 2 din
  wire [2:0] pinIn;
  reg [2:0] pinFilt_ff;
  wire [2:0] pinStable;
  wire [2:0] pinNow;

  assign pinIn = {spiDin, spiCsN, spiSclk};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : gSync
      reg [2:0] sync_ff;
      always @(posedge clock) begin
        if (srst) begin
          sync_ff <= 3'h7;
        end else begin
          sync_ff <= {sync_ff[1:0], pinIn[gi]};
        end
      end
      // a change counts once the second and third stages agree
      assign pinStable[gi] = (sync_ff[1] == sync_ff[2]);
      assign pinNow[gi] = sync_ff[2];
    end
  endgenerate

  always @(posedge clock) begin
    if (srst) begin
      pinFilt_ff <= 3'h7;
    end else begin
      pinFilt_ff <= (pinStable & pinNow) | (~pinStable & pinFilt_ff);
    end
  end

  wire sclkRise = pinStable[0] & pinNow[0] & ~pinFilt_ff[0];
  wire sclkFall = pinStable[0] & ~pinNow[0] & pinFilt_ff[0];
  wire csFall = pinStable[1] & ~pinNow[1] & pinFilt_ff[1];
  wire csActive = ~pinFilt_ff[1];

  // frame receive and transmit
  reg [15:0] rxShift_ff;
  reg [15:0] txShift_ff;
  reg [4:0] bitCnt_ff;
  reg [15:0] readWord_ff;

  wire bitTake = sclkRise & csActive & (bitCnt_ff != `MCS_FRAME_FULL);
  wire frameDone = bitTake & (bitCnt_ff == `MCS_FRAME_LAST);
  // filtered data level, long settled by the time sclk rises
  wire [15:0] rxWord = {rxShift_ff[14:0], pinFilt_ff[2]};
  wire frameWrite = frameDone & rxWord[`MCS_FRAME_WR_BIT];
  wire [6:0] frameAddr = rxWord[14:8];
  wire [7:0] frameData = rxWord[7:0];

  wire wrCtrlLo = frameWrite & (frameAddr == `MCS_ADDR_CTRL_LO);
  wire wrCtrlHi = frameWrite & (frameAddr == `MCS_ADDR_CTRL_HI);
  wire wrDacLo = frameWrite & (frameAddr == `MCS_ADDR_DAC_LO);
  wire wrDacHi = frameWrite & (frameAddr == `MCS_ADDR_DAC_HI);
  wire dacLatch = frameWrite & (frameAddr == `MCS_ADDR_CMD_LO)
    & frameData[`MCS_BIT_CMD_DAC_LATCH];

  assign spiDoutOe = csActive;

  always @(posedge clock) begin
    if (srst) begin
      rxShift_ff <= 16'h0000;
      txShift_ff <= 16'h0000;
      bitCnt_ff <= 5'h00;
      spiDout_ff <= 1'b0;
    end else begin
      if (csFall) begin
        bitCnt_ff <= 5'h00;
        txShift_ff <= readWord_ff;
      end else begin
        if (bitTake) begin
          rxShift_ff <= rxWord;
          bitCnt_ff <= bitCnt_ff + 5'h01;
        end
        // mode 3: next bit goes out on each falling edge
        if (sclkFall & csActive) begin
          spiDout_ff <= txShift_ff[15];
          txShift_ff <= {txShift_ff[14:0], 1'b0};
        end
      end
    end
  end

  // control register
  reg [15:0] ctrl_ff;
  reg [15:0] nxt_ctrl;

  always @* begin
    nxt_ctrl = ctrl_ff;
    if (selfTestDone) begin
      nxt_ctrl[`MCS_BIT_SELF_TEST] = 1'b0;
    end
    if (memTestDone) begin
      nxt_ctrl[`MCS_BIT_MEM_TEST] = 1'b0;
    end
    if (wrCtrlLo) begin
      nxt_ctrl[7:0] = frameData & `MCS_CTRL_MASK_LO;
    end
    if (wrCtrlHi) begin
      // a running test is not aborted by writing zero; a new one wins over done
      nxt_ctrl[15:8] = (frameData & `MCS_CTRL_MASK_HI)
        | (nxt_ctrl[15:8] & `MCS_CTRL_TRIG_HI);
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      ctrl_ff <= `MCS_CTRL_RESET;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign selfTestRun = ctrl_ff[`MCS_BIT_SELF_TEST];
  assign memTestRun = ctrl_ff[`MCS_BIT_MEM_TEST];
  assign stimNegative = ctrl_ff[`MCS_BIT_STIM_NEG];
  assign stimPositive = ctrl_ff[`MCS_BIT_STIM_POS];
  assign accelBiasCompEnable = ctrl_ff[`MCS_BIT_BIAS_COMP];
  assign originAlignEnable = ctrl_ff[`MCS_BIT_ORIGIN_ALIGN];

  // test results forwarded to the diagnostic flags
  always @(posedge clock) begin
    if (srst) begin
      diagSensorFail_ff <= 6'h00;
      diagSensorStrobe_ff <= 1'b0;
      diagChecksumFail_ff <= 1'b0;
      diagChecksumStrobe_ff <= 1'b0;
    end else begin
      diagSensorStrobe_ff <= selfTestDone & ctrl_ff[`MCS_BIT_SELF_TEST];
      diagChecksumStrobe_ff <= memTestDone & ctrl_ff[`MCS_BIT_MEM_TEST];
      if (selfTestDone & ctrl_ff[`MCS_BIT_SELF_TEST]) begin
        diagSensorFail_ff <= selfTestFail;
      end
      if (memTestDone & ctrl_ff[`MCS_BIT_MEM_TEST]) begin
        diagChecksumFail_ff <= memTestFail;
      end
    end
  end

  // converter holding and input registers
  reg [15:0] dacHold_ff;

  always @(posedge clock) begin
    if (srst) begin
      dacHold_ff <= `MCS_DAC_RESET;
      converterInput_ff <= 12'h000;
    end else begin
      if (wrDacLo) begin
        dacHold_ff[7:0] <= frameData;
      end
      if (wrDacHi) begin
        dacHold_ff[15:8] <= frameData & `MCS_DAC_MASK_HI;
      end
      // latch bit is not stored, so it reads back zero once done
      if (dacLatch) begin
        converterInput_ff <= dacHold_ff[`MCS_DAC_MSB:0];
      end
    end
  end

  // read data returned in the next frame
  always @(posedge clock) begin
    if (srst) begin
      readWord_ff <= 16'h0000;
    end else if (frameDone & ~rxWord[`MCS_FRAME_WR_BIT]) begin
      case ({frameAddr[6:1], 1'b0})
        `MCS_ADDR_CTRL_LO: begin
          readWord_ff <= ctrl_ff;
        end
        `MCS_ADDR_DAC_LO: begin
          readWord_ff <= dacHold_ff;
        end
        default: begin
          readWord_ff <= 16'h0000;
        end
      endcase
    end
  end

  // data-ready pulse generator
  reg [11:0] drdyCnt_ff;
  wire drdyActive = (drdyCnt_ff != 12'h000);
  wire drdyEnable = ctrl_ff[`MCS_BIT_DRDY_EN];

  always @(posedge clock) begin
    if (srst) begin
      drdyCnt_ff <= 12'h000;
    end else if (drdyActive) begin
      drdyCnt_ff <= drdyCnt_ff - 12'h001;
    end else if (sampleTick & drdyEnable) begin
      drdyCnt_ff <= DRDY_CYCLES;
    end
  end

  // a pulse in flight finishes even if the enable drops, keeping its width
  wire drdyDrive = drdyEnable | drdyActive;
  wire drdyLevel = ctrl_ff[`MCS_BIT_DRDY_POL] ? drdyActive : ~drdyActive;
  wire drdyLine2 = ctrl_ff[`MCS_BIT_LINE_SEL];

  assign ioLine1Out = drdyLevel;
  assign ioLine1Oe = drdyDrive & ~drdyLine2;
  assign ioLine2Out = drdyLevel;
  assign ioLine2Oe = drdyDrive & drdyLine2;

  // external sample clock condition
  assign extClockEnable = ~gpioLine3Output & (samplePeriod == `MCS_SMPL_EXT);

endmodule
`default_nettype wire

// [src/mcs_consts.vh]
// constants for the miscellaneous control and auxiliary converter bank
// assumes 16-bit serial frames and a 40 MHz device clock
`ifndef MCS_CONSTS_VH
`define MCS_CONSTS_VH

// byte addresses carried in bits 14:8 of a frame
`define MCS_ADDR_DAC_LO 7'h30
`define MCS_ADDR_DAC_HI 7'h31
`define MCS_ADDR_CTRL_LO 7'h34
`define MCS_ADDR_CTRL_HI 7'h35
`define MCS_ADDR_CMD_LO 7'h3E

// frame layout
`define MCS_FRAME_WR_BIT 15
`define MCS_FRAME_LAST 5'h0F
`define MCS_FRAME_FULL 5'h10

// reset values
`define MCS_CTRL_RESET 16'h0006
`define MCS_DAC_RESET 16'h0000

// writable bits per byte
`define MCS_CTRL_MASK_LO 8'hC7
`define MCS_CTRL_MASK_HI 8'h0F
`define MCS_CTRL_TRIG_HI 8'h0C
`define MCS_DAC_MASK_HI 8'h0F

// misc_control fields
`define MCS_BIT_LINE_SEL 0
`define MCS_BIT_DRDY_POL 1
`define MCS_BIT_DRDY_EN 2
`define MCS_BIT_ORIGIN_ALIGN 6
`define MCS_BIT_BIAS_COMP 7
`define MCS_BIT_STIM_POS 8
`define MCS_BIT_STIM_NEG 9
`define MCS_BIT_SELF_TEST 10
`define MCS_BIT_MEM_TEST 11

// global_command low byte field
`define MCS_BIT_CMD_DAC_LATCH 2

// converter code width
`define MCS_DAC_MSB 11

// external sample clock condition
`define MCS_SMPL_EXT 8'h00

// timing
`define MCS_CLK_MHZ 40
`define MCS_DRDY_MIN_US 100
`define MCS_DRDY_MAX_US 200

`endif

// [dv/mcs_misc_control_monitor.sv]
// concurrent checks on the misc control bank ports
// assumes one clock domain with synchronous active-high srst
`timescale 1ns/100ps
`default_nettype none
module mcs_misc_control_monitor (
  // clock and reset
  input wire clock,
  input wire srst,
  // serial port
  input wire spiCsN,
  input wire spiDoutOe,
  // sampling context
  input wire gpioLine3Output,
  input wire [7:0] samplePeriod,
  input wire extClockEnable,
  // data-ready lines
  input wire ioLine1Out,
  input wire ioLine1Oe,
  input wire ioLine2Oe,
  // test engines
  input wire selfTestRun,
  input wire selfTestDone,
  input wire diagSensorStrobe_ff,
  input wire memTestRun,
  input wire memTestDone,
  input wire diagChecksumStrobe_ff,
  // converter
  input wire [11:0] converterInput_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  property p_ext; extClockEnable == (!gpioLine3Output && samplePeriod == 8'h00); endproperty
  a_ext: assert property (p_ext) else $error("ext clock enable wrong");
  property p_one_line; !(ioLine1Oe && ioLine2Oe); endproperty
  a_one_line: assert property (p_one_line) else $error("both lines driven");
  property p_reset;
    $fell(srst) |-> ioLine1Oe && !ioLine1Out && !ioLine2Oe && !selfTestRun && !memTestRun
      && converterInput_ff == 12'h000;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_self_end;
    selfTestRun && selfTestDone |=> !selfTestRun && diagSensorStrobe_ff;
  endproperty
  a_self_end: assert property (p_self_end) else $error("self test end wrong");
  property p_self_hold; selfTestRun && !selfTestDone |=> selfTestRun; endproperty
  a_self_hold: assert property (p_self_hold) else $error("self test dropped");
  property p_mem_end;
    memTestRun && memTestDone |=> !memTestRun && diagChecksumStrobe_ff;
  endproperty
  a_mem_end: assert property (p_mem_end) else $error("mem test end wrong");
  property p_mem_hold; memTestRun && !memTestDone |=> memTestRun; endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("mem test dropped");
  property p_mem_cause; diagChecksumStrobe_ff |-> $past(memTestDone); endproperty
  a_mem_cause: assert property (p_mem_cause) else $error("stray checksum strobe");
  // select held low through the synchroniser turns the data output on
  property p_dout_oe; (!spiCsN) [*5] |-> spiDoutOe; endproperty
  a_dout_oe: assert property (p_dout_oe) else $error("data out not enabled");
  c_self: cover property (selfTestRun && selfTestDone);
  c_mem: cover property (memTestRun && memTestDone);
  c_dac: cover property ($changed(converterInput_ff));
endmodule
bind mcs_misc_control mcs_misc_control_monitor i_mcs_misc_control_monitor (
  .clock(clock), .srst(srst), .spiCsN(spiCsN), .spiDoutOe(spiDoutOe),
  .gpioLine3Output(gpioLine3Output),
  .samplePeriod(samplePeriod), .extClockEnable(extClockEnable), .ioLine1Out(ioLine1Out),
  .ioLine1Oe(ioLine1Oe), .ioLine2Oe(ioLine2Oe), .selfTestRun(selfTestRun),
  .selfTestDone(selfTestDone), .diagSensorStrobe_ff(diagSensorStrobe_ff),
  .memTestRun(memTestRun), .memTestDone(memTestDone),
  .diagChecksumStrobe_ff(diagChecksumStrobe_ff), .converterInput_ff(converterInput_ff));
`default_nettype wire

// [dv/mcs_spi_host.sv]
// serial host model issuing mode 3 frames
// assumes the caller enters frame() at a falling clock edge
`timescale 1ns/100ps
`default_nettype none
module mcs_spi_host (
  // device clock
  input wire clock,
  // serial pins
  output logic csN,
  output logic sclk,
  output logic din,
  input wire dout
);
  initial begin
    csN = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  // 16 bits msb first; half sets the sclk half period in clocks
  task automatic frame(input logic [15:0] tx, input int half, output logic [15:0] rx);
    csN = 1'b0;
    repeat (half) @(negedge clock);
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      din = tx[i];
      repeat (half) @(negedge clock);
      rx[i] = dout;
      sclk = 1'b1;
      repeat (half) @(negedge clock);
    end
    csN = 1'b1;
    din = ~din;
    repeat (6) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// [dv/tb_mcs_misc_control.sv]
// bench for the misc control bank: frames, data-ready, tests, converter
// assumes the serial host model and a 40 MHz clock
`timescale 1ns/100ps
`default_nettype none
module tb_mcs_misc_control;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic sampleTick = 1'b0, gpioLine3Output = 1'b0, selfTestDone = 1'b0;
  logic memTestDone = 1'b0, memTestFail = 1'b0;
  logic [7:0] samplePeriod = 8'h00;
  logic [5:0] selfTestFail = 6'h00;
  wire spiCsN, spiSclk, spiDin, spiDout_ff, extClockEnable, ioLine1Out, ioLine1Oe, ioLine2Oe;
  wire selfTestRun, diagSensorStrobe_ff, memTestRun, diagChecksumFail_ff, diagChecksumStrobe_ff;
  wire stimNegative, stimPositive, accelBiasCompEnable, originAlignEnable;
  wire ioLine2Out, spiDoutOe;
  wire [5:0] diagSensorFail_ff;
  wire [11:0] converterInput_ff;
  integer failCount = 0;
  integer checksDone = 0;
  logic [15:0] rx;
  mcs_spi_host i_mcs_spi_host (.clock(clock), .csN(spiCsN), .sclk(spiSclk), .din(spiDin),
    .dout(spiDout_ff));
  mcs_misc_control i_mcs_misc_control (.clock(clock), .srst(srst), .spiCsN(spiCsN),
    .spiSclk(spiSclk), .spiDin(spiDin), .spiDout_ff(spiDout_ff), .spiDoutOe(spiDoutOe),
    .sampleTick(sampleTick), .gpioLine3Output(gpioLine3Output), .samplePeriod(samplePeriod),
    .extClockEnable(extClockEnable), .ioLine1Out(ioLine1Out), .ioLine1Oe(ioLine1Oe),
    .ioLine2Out(ioLine2Out), .ioLine2Oe(ioLine2Oe), .selfTestRun(selfTestRun),
    .selfTestDone(selfTestDone), .selfTestFail(selfTestFail),
    .diagSensorFail_ff(diagSensorFail_ff), .diagSensorStrobe_ff(diagSensorStrobe_ff),
    .memTestRun(memTestRun), .memTestDone(memTestDone), .memTestFail(memTestFail),
    .diagChecksumFail_ff(diagChecksumFail_ff), .diagChecksumStrobe_ff(diagChecksumStrobe_ff),
    .stimNegative(stimNegative), .stimPositive(stimPositive),
    .accelBiasCompEnable(accelBiasCompEnable), .originAlignEnable(originAlignEnable),
    .converterInput_ff(converterInput_ff));
  always #12.5 clock = ~clock;
  task automatic printVerdict;
    if (failCount == 0 && checksDone > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failCount++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] f);
    i_mcs_spi_host.frame(f, 6, rx);
  endtask
  // read data comes back in the following frame
  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    i_mcs_spi_host.frame({1'b0, a, 8'h00}, 4, rx);
    i_mcs_spi_host.frame(16'h0000, 9, v);
  endtask
  task automatic tick;
    sampleTick = 1'b1;
    @(negedge clock);
    sampleTick = 1'b0;
  endtask
  initial begin
    logic [15:0] v;
    int n, i;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    repeat (4) @(negedge clock);
    chk("lines", 16'({ioLine1Oe, ioLine1Out, ioLine2Oe}), 16'h0004);
    chk("doe", 16'(spiDoutOe), 16'h0000);
    rd(7'h34, v);
    chk("ctrl", v, 16'h0006);
    rd(7'h31, v);
    chk("dac", v, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      gpioLine3Output = k[0];
      samplePeriod = k[1] ? 8'h05 : 8'h00;
      @(negedge clock);
      chk("ext", 16'(extClockEnable), 16'(k == 0));
    end
    for (int k = 0; k < 4; k++) begin
      wr(16'hB404 | 16'(k));
      chk("idle", 16'(ioLine1Out), 16'(!k[1]));
      chk("idle2", 16'(ioLine2Out), 16'(!k[1]));
      chk("oe", 16'({ioLine2Oe, ioLine1Oe}), k[0] ? 16'h0002 : 16'h0001);
      tick();
      n = 0;
      for (i = 0; i < 5000 && (n == 0 || ioLine1Out === k[1]); i++) begin
        if (ioLine1Out === k[1]) n++;
        @(negedge clock);
      end
      if (i == 5000) begin
        failCount++;
        printVerdict();
      end
      chk("width", 16'(n), 16'h0FA0);
    end
    wr(16'hB5FF);
    wr(16'hB4FF);
    chk("ctl", 16'({memTestRun, selfTestRun, stimNegative, stimPositive,
      accelBiasCompEnable, originAlignEnable}), 16'h003F);
    rd(7'h35, v);
    chk("ctrl", v, 16'h0FC7);
    for (int j = 2; j >= 0; j--) begin
      wr(16'hB500 | 16'(j));
      chk("stim", 16'({memTestRun, selfTestRun, stimNegative, stimPositive}),
        16'(12 + j));
    end
    selfTestFail = 6'h2A;
    memTestFail = 1'b1;
    selfTestDone = 1'b1;
    memTestDone = 1'b1;
    @(negedge clock);
    selfTestDone = 1'b0;
    memTestDone = 1'b0;
    chk("diag", 16'({diagSensorStrobe_ff, diagSensorFail_ff, diagChecksumStrobe_ff,
      diagChecksumFail_ff, selfTestRun, memTestRun}), 16'h06AC);
    rd(7'h34, v);
    chk("ctrl", v, 16'h00C7);
    wr(16'hB0D9);
    wr(16'hB1FF);
    chk("dacin", 16'(converterInput_ff), 16'h0000);
    rd(7'h30, v);
    chk("dac", v, 16'h0FD9);
    wr(16'hB104);
    wr(16'hBE04);
    chk("dacin", 16'(converterInput_ff), 16'h04D9);
    rd(7'h20, v);
    chk("unmapped", v, 16'h0000);
    wr(16'hB400);
    tick();
    repeat (3) @(negedge clock);
    chk("off", 16'({ioLine2Oe, ioLine1Oe}), 16'h0000);
    printVerdict();
  end
endmodule
`default_nettype wire
